// *** hdl/ufd_pkg.sv ***
package ufd_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] OFS_DATA     = 3'h0;
	localparam logic [2:0] OFS_INT_EN   = 3'h1;
	localparam logic [2:0] OFS_INT_FIFO = 3'h2;
	localparam logic [2:0] OFS_LINE     = 3'h3;
	localparam logic [2:0] OFS_DIV_LO   = 3'h4;
	localparam logic [2:0] OFS_DIV_HI   = 3'h5;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int IE_RX_BIT      = 0;
	localparam int IE_TX_BIT      = 1;
	localparam int IE_LINE_BIT    = 2;
	localparam int FC_ENABLE_BIT  = 0;
	localparam int FC_RX_CLR_BIT  = 1;
	localparam int FC_TX_CLR_BIT  = 2;
	localparam int FC_DMA_BIT     = 3;
	localparam int FC_TRIG_LO     = 6;
	localparam int LS_READY_BIT   = 0;
	localparam int LS_OVERRUN_BIT = 1;
	localparam int LS_TX_EMPTY    = 5;
	localparam int LS_TX_IDLE     = 6;

	// ----------------------------------------------------------------
	// interrupt identity codes, read at the control offset
	// ----------------------------------------------------------------
	localparam logic [7:0] IID_NONE    = 8'h01;
	localparam logic [7:0] IID_LINE    = 8'h06;
	localparam logic [7:0] IID_RX      = 8'h04;
	localparam logic [7:0] IID_TIMEOUT = 8'h0C;
	localparam logic [7:0] IID_TX      = 8'h02;
	localparam logic [7:0] IID_FIFO_ON = 8'hC0;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0]  INT_EN_RESET  = 8'h00;
	localparam logic [7:0]  FCTRL_RESET   = 8'h00;
	localparam logic [15:0] DIVISOR_RESET = 16'h0001;
	localparam int          FIFO_DEPTH    = 16;
	localparam int          FRAME_BITS    = 10;
	localparam int          TIMEOUT_CHARS = 4;

endpackage : ufd_pkg

// *** hdl/ufd_core.sv ***
// Functional notes
// - separate sixteen-byte transmit and receive FIFOs
// - software picks receive trigger of 1, 4, 8 or 14 bytes
// - receive FIFO fills to sixteen whatever trigger is chosen
// - transmitter starts shifting as soon as a byte is written
// - writes to a full transmit FIFO are refused until a byte moves on
// - transmit-empty interrupt while FIFO empty and enabled
// - transmit-empty interrupt drops at the first byte written
// - one character delay before new transmit-empty after first load
// - delay cancelled once two bytes have been held together
// - receive interrupt when count reaches trigger and enabled
// - full receive FIFO drops characters and sets overrun
// - timeout after four idle character times with data present
// - timeout cleared by a host read or a new character
// - single-transfer and multi-transfer DMA request modes
// - single mode: receive request while receive FIFO not empty
// - single mode: transmit request while transmit FIFO empty
// - multi mode: receive request from trigger or timeout until empty
// - multi mode: transmit request while a free entry remains
// - FIFOs disabled after reset until software enables them
// - interrupt output is a level while anything enabled is pending
`timescale 1ns/10ps
module ufd_core #(
	parameter int DEPTH = ufd_pkg::FIFO_DEPTH,
	parameter int PTR_W = 4
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// register port
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	// receiver side
	input  wire logic       rx_char_valid,
	input  wire logic [7:0] rx_char_data,
	// serial output
	output logic            serial_tx_line,
	// service requests
	output logic            intr,
	output logic            rx_dma_req,
	output logic            tx_dma_req
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [PTR_W:0] trig_count(input logic [1:0] sel);
		unique case (sel)
			2'b00: trig_count = (PTR_W+1)'(1);
			2'b01: trig_count = (PTR_W+1)'(4);
			2'b10: trig_count = (PTR_W+1)'(8);
			2'b11: trig_count = (PTR_W+1)'(14);
		endcase
	endfunction : trig_count

	localparam logic [7:0] FRAME_B = 8'(ufd_pkg::FRAME_BITS);
	localparam logic [7:0] TOUT_B  =
		8'(ufd_pkg::FRAME_BITS * ufd_pkg::TIMEOUT_CHARS);
	localparam logic [3:0] FRAME_4 = 4'(ufd_pkg::FRAME_BITS);

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	logic [7:0]  int_en_reg;
	logic        fifo_en_reg;
	logic        dma_multi_reg;
	logic [1:0]  trig_sel_reg;
	logic [15:0] divisor_reg;
	logic        wr_fctrl;
	logic        fifo_clear_rx;
	logic        fifo_clear_tx;

	assign wr_fctrl      = reg_write && reg_addr == ufd_pkg::OFS_INT_FIFO;
	assign fifo_clear_rx = wr_fctrl && (reg_wdata[ufd_pkg::FC_RX_CLR_BIT]
		|| reg_wdata[ufd_pkg::FC_ENABLE_BIT] != fifo_en_reg);
	assign fifo_clear_tx = wr_fctrl && (reg_wdata[ufd_pkg::FC_TX_CLR_BIT]
		|| reg_wdata[ufd_pkg::FC_ENABLE_BIT] != fifo_en_reg);

	always_ff @(posedge clock) begin
		if (reset) begin
			fifo_en_reg   <= ufd_pkg::FCTRL_RESET[ufd_pkg::FC_ENABLE_BIT];
			dma_multi_reg <= ufd_pkg::FCTRL_RESET[ufd_pkg::FC_DMA_BIT];
			trig_sel_reg  <= ufd_pkg::FCTRL_RESET[ufd_pkg::FC_TRIG_LO +: 2];
		end else if (wr_fctrl) begin
			fifo_en_reg   <= reg_wdata[ufd_pkg::FC_ENABLE_BIT];
			dma_multi_reg <= reg_wdata[ufd_pkg::FC_DMA_BIT];
			trig_sel_reg  <= reg_wdata[ufd_pkg::FC_TRIG_LO +: 2];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			int_en_reg  <= ufd_pkg::INT_EN_RESET;
			divisor_reg <= ufd_pkg::DIVISOR_RESET;
		end else if (reg_write) begin
			if (reg_addr == ufd_pkg::OFS_INT_EN)
				int_en_reg <= reg_wdata;
			if (reg_addr == ufd_pkg::OFS_DIV_LO)
				divisor_reg[7:0] <= reg_wdata;
			if (reg_addr == ufd_pkg::OFS_DIV_HI)
				divisor_reg[15:8] <= reg_wdata;
		end
	end

	// unbuffered mode acts as a one-entry holding register
	logic [PTR_W:0] capacity;
	logic [PTR_W:0] trigger;
	assign capacity = fifo_en_reg ? (PTR_W+1)'(DEPTH) : (PTR_W+1)'(1);
	assign trigger  = fifo_en_reg ? trig_count(trig_sel_reg)
	                              : (PTR_W+1)'(1);

	// ----------------------------------------------------------------
	// bit-time tick for the timers
	// ----------------------------------------------------------------
	// bit time built from the divisor alone; the timers count bit ticks up to character times
	logic [15:0] tick_cnt_reg;
	logic        bit_tick;
	assign bit_tick = tick_cnt_reg + 16'h0001 >= divisor_reg;

	always_ff @(posedge clock) begin
		if (reset || bit_tick)
			tick_cnt_reg <= 16'h0000;
		else
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
	end

	// ----------------------------------------------------------------
	// transmit FIFO
	// ----------------------------------------------------------------
	// transmit storage
	logic [7:0]     tx_mem [DEPTH];
	logic [PTR_W-1:0] tx_wr_reg;
	logic [PTR_W-1:0] tx_rd_reg;
	logic [PTR_W:0] tx_count_reg;
	logic           tx_push;
	logic           tx_pop;
	logic           tx_busy_reg;

	assign tx_push = reg_write && reg_addr == ufd_pkg::OFS_DATA
		&& tx_count_reg < capacity;
	// start as soon as a byte is present
	assign tx_pop  = !tx_busy_reg && tx_count_reg != '0;

	always_ff @(posedge clock) begin
		if (tx_push)
			tx_mem[tx_wr_reg] <= reg_wdata;
	end

	always_ff @(posedge clock) begin
		if (reset || fifo_clear_tx) begin
			tx_wr_reg    <= '0;
			tx_rd_reg    <= '0;
			tx_count_reg <= '0;
		end else begin
			if (tx_push)
				tx_wr_reg <= tx_wr_reg + PTR_W'(1);
			if (tx_pop)
				tx_rd_reg <= tx_rd_reg + PTR_W'(1);
			tx_count_reg <= tx_count_reg + (PTR_W+1)'(tx_push)
				- (PTR_W+1)'(tx_pop);
		end
	end

	// ----------------------------------------------------------------
	// transmit shifter
	// ----------------------------------------------------------------
	logic [9:0]  tx_shift_reg;
	logic [3:0]  tx_bits_reg;
	logic [15:0] tx_phase_reg;
	logic        tx_phase_end;
	assign tx_phase_end = tx_phase_reg + 16'h0001 >= divisor_reg;

	always_ff @(posedge clock) begin
		if (reset) begin
			tx_busy_reg  <= 1'b0;
			tx_shift_reg <= 10'h3FF;
			tx_bits_reg  <= 4'h0;
			tx_phase_reg <= 16'h0000;
		end else if (tx_pop) begin
			// phase restarts so the start bit is full length
			tx_busy_reg  <= 1'b1;
			tx_shift_reg <= {1'b1, tx_mem[tx_rd_reg], 1'b0};
			tx_bits_reg  <= 4'h0;
			tx_phase_reg <= 16'h0000;
		end else if (tx_busy_reg) begin
			if (tx_phase_end) begin
				tx_phase_reg <= 16'h0000;
				tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
				tx_bits_reg  <= tx_bits_reg + 4'h1;
				if (tx_bits_reg == FRAME_4 - 4'h1)
					tx_busy_reg <= 1'b0;
			end else begin
				tx_phase_reg <= tx_phase_reg + 16'h0001;
			end
		end
	end

	assign serial_tx_line = tx_busy_reg ? tx_shift_reg[0] : 1'b1;

	// ----------------------------------------------------------------
	// transmit-empty hold-off
	// ----------------------------------------------------------------
	logic       tx_hold_reg;
	logic [7:0] tx_hold_cnt_reg;

	always_ff @(posedge clock) begin
		if (reset || fifo_clear_tx) begin
			tx_hold_reg     <= 1'b0;
			tx_hold_cnt_reg <= 8'h00;
		end else if (tx_push && tx_count_reg == '0) begin
			// first load into empty FIFO arms delay
			tx_hold_reg     <= 1'b1;
			tx_hold_cnt_reg <= 8'h00;
		end else if (tx_count_reg >= (PTR_W+1)'(2)) begin
			tx_hold_reg <= 1'b0;
		end else if (tx_hold_reg && bit_tick) begin
			tx_hold_cnt_reg <= tx_hold_cnt_reg + 8'h01;
			if (tx_hold_cnt_reg + 8'h01 >= FRAME_B)
				tx_hold_reg <= 1'b0;
		end
	end

	logic tx_empty_pend;
	assign tx_empty_pend = tx_count_reg == '0 && !tx_hold_reg;

	// ----------------------------------------------------------------
	// receive FIFO
	// ----------------------------------------------------------------
	// receive storage
	logic [7:0]       rx_mem [DEPTH];
	logic [PTR_W-1:0] rx_wr_reg;
	logic [PTR_W-1:0] rx_rd_reg;
	logic [PTR_W:0]   rx_count_reg;
	logic             rx_push;
	logic             rx_pop;
	logic             rx_read;

	// fill to capacity regardless of trigger
	assign rx_push = rx_char_valid && rx_count_reg < capacity;
	assign rx_read = reg_read && reg_addr == ufd_pkg::OFS_DATA;
	assign rx_pop  = rx_read && rx_count_reg != '0;

	always_ff @(posedge clock) begin
		if (rx_push)
			rx_mem[rx_wr_reg] <= rx_char_data;
	end

	always_ff @(posedge clock) begin
		if (reset || fifo_clear_rx) begin
			rx_wr_reg    <= '0;
			rx_rd_reg    <= '0;
			rx_count_reg <= '0;
		end else begin
			if (rx_push)
				rx_wr_reg <= rx_wr_reg + PTR_W'(1);
			if (rx_pop)
				rx_rd_reg <= rx_rd_reg + PTR_W'(1);
			rx_count_reg <= rx_count_reg + (PTR_W+1)'(rx_push)
				- (PTR_W+1)'(rx_pop);
		end
	end

	// overrun; set wins over read clear
	logic overrun_reg;
	always_ff @(posedge clock) begin
		if (reset)
			overrun_reg <= 1'b0;
		else if (rx_char_valid && !rx_push)
			overrun_reg <= 1'b1;
		else if (reg_read && reg_addr == ufd_pkg::OFS_LINE)
			overrun_reg <= 1'b0;
	end

	// ----------------------------------------------------------------
	// receive timeout
	// ----------------------------------------------------------------
	logic [7:0] rx_idle_cnt_reg;
	logic       timeout_reg;

	always_ff @(posedge clock) begin
		if (reset || fifo_clear_rx || !fifo_en_reg) begin
			rx_idle_cnt_reg <= 8'h00;
			timeout_reg     <= 1'b0;
		end else if (rx_push || rx_read) begin
			rx_idle_cnt_reg <= 8'h00;
			timeout_reg     <= 1'b0;
		end else if (rx_count_reg != '0 && bit_tick && !timeout_reg) begin
			rx_idle_cnt_reg <= rx_idle_cnt_reg + 8'h01;
			if (rx_idle_cnt_reg + 8'h01 >= TOUT_B)
				timeout_reg <= 1'b1;
		end
	end

	logic rx_level;
	assign rx_level = rx_count_reg >= trigger;

	// ----------------------------------------------------------------
	// DMA requests
	// ----------------------------------------------------------------
	logic rx_dma_multi_reg;
	always_ff @(posedge clock) begin
		if (reset || rx_count_reg == '0)
			rx_dma_multi_reg <= 1'b0;
		// set by trigger or timeout, held until empty
		else if (rx_level || timeout_reg)
			rx_dma_multi_reg <= 1'b1;
	end

	logic multi_mode;
	assign multi_mode = dma_multi_reg && fifo_en_reg;

	always_comb begin
		if (multi_mode) begin
			// rises with the level, drops in the cycle the FIFO empties
			rx_dma_req = rx_count_reg != '0
				&& (rx_dma_multi_reg || rx_level || timeout_reg);
			tx_dma_req = tx_count_reg < capacity;
		end else begin
			rx_dma_req = rx_count_reg != '0;
			tx_dma_req = tx_count_reg == '0;
		end
	end

	// ----------------------------------------------------------------
	// interrupt
	// ----------------------------------------------------------------
	logic line_pend;
	logic rx_pend;
	logic tout_pend;
	logic tx_pend;
	assign line_pend = int_en_reg[ufd_pkg::IE_LINE_BIT] && overrun_reg;
	assign rx_pend   = int_en_reg[ufd_pkg::IE_RX_BIT] && rx_level;
	assign tout_pend = int_en_reg[ufd_pkg::IE_RX_BIT] && timeout_reg;
	assign tx_pend   = int_en_reg[ufd_pkg::IE_TX_BIT] && tx_empty_pend;
	assign intr = line_pend || rx_pend || tout_pend || tx_pend;

	// ----------------------------------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------------------------------
	logic [7:0] iid;
	always_comb begin
		if (line_pend)
			iid = ufd_pkg::IID_LINE;
		else if (rx_pend)
			iid = ufd_pkg::IID_RX;
		else if (tout_pend)
			iid = ufd_pkg::IID_TIMEOUT;
		else if (tx_pend)
			iid = ufd_pkg::IID_TX;
		else
			iid = ufd_pkg::IID_NONE;
		if (fifo_en_reg)
			iid = iid | ufd_pkg::IID_FIFO_ON;
	end

	logic [7:0] line_stat;
	always_comb begin
		line_stat = 8'h00;
		line_stat[ufd_pkg::LS_READY_BIT]   = rx_count_reg != '0;
		line_stat[ufd_pkg::LS_OVERRUN_BIT] = overrun_reg;
		line_stat[ufd_pkg::LS_TX_EMPTY]    = tx_count_reg == '0;
		line_stat[ufd_pkg::LS_TX_IDLE]     =
			tx_count_reg == '0 && !tx_busy_reg;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			unique case (reg_addr)
				ufd_pkg::OFS_DATA:
					reg_rdata <= rx_mem[rx_rd_reg];
				ufd_pkg::OFS_INT_EN:   reg_rdata <= int_en_reg;
				ufd_pkg::OFS_INT_FIFO: reg_rdata <= iid;
				ufd_pkg::OFS_LINE:     reg_rdata <= line_stat;
				ufd_pkg::OFS_DIV_LO:   reg_rdata <= divisor_reg[7:0];
				ufd_pkg::OFS_DIV_HI:   reg_rdata <= divisor_reg[15:8];
				default:               reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule : ufd_core

// *** verification/ufd_core_monitor.sv ***
`timescale 1ns/10ps
module ufd_core_monitor (
	// clock and reset
	input wire logic       clock,
	input wire logic       reset,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	// line and requests
	input wire logic       rx_char_valid,
	input wire logic [7:0] rx_char_data,
	input wire logic       serial_tx_line,
	input wire logic       intr,
	input wire logic       rx_dma_req,
	input wire logic       tx_dma_req
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	logic       en_reg;
	logic       multi_reg;
	logic [2:0] ie_reg;
	logic       single;
	logic       wd;
	assign single = !(en_reg && multi_reg);
	assign wd = reg_write && reg_addr == ufd_pkg::OFS_DATA;
	always_ff @(posedge clock) begin
		if (reset) begin
			en_reg <= 1'b0;
			multi_reg <= 1'b0;
		end else if (reg_write && reg_addr == ufd_pkg::OFS_INT_FIFO) begin
			en_reg <= reg_wdata[ufd_pkg::FC_ENABLE_BIT];
			multi_reg <= reg_wdata[ufd_pkg::FC_DMA_BIT];
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			ie_reg <= 3'h0;
		end else if (reg_write && reg_addr == ufd_pkg::OFS_INT_EN) begin
			ie_reg <= reg_wdata[2:0];
		end
	end
	property p_reset_state;
		$fell(reset) |-> tx_dma_req && !rx_dma_req && serial_tx_line && !intr;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("reset state");
	property p_ident_off;
		reg_read && reg_addr == ufd_pkg::OFS_INT_FIFO && !en_reg
			|=> reg_rdata[7:6] == 2'b00;
	endproperty
	a_ident_off: assert property (p_ident_off)
		else $error("fifo flag set");
	property p_ident_on;
		reg_read && reg_addr == ufd_pkg::OFS_INT_FIFO && en_reg
			|=> reg_rdata[7:6] == 2'b11;
	endproperty
	a_ident_on: assert property (p_ident_on)
		else $error("fifo flag clear");
	property p_level_intr;
		!en_reg && ie_reg[ufd_pkg::IE_RX_BIT] && rx_dma_req |-> intr;
	endproperty
	a_level_intr: assert property (p_level_intr)
		else $error("no rx level");
	property p_rx_req;
		single && rx_char_valid && !reg_read && !reg_write |=> rx_dma_req;
	endproperty
	a_rx_req: assert property (p_rx_req)
		else $error("rx request low");
	property p_tx_req;
		single && wd |=> !tx_dma_req;
	endproperty
	a_tx_req: assert property (p_tx_req)
		else $error("tx request high");
	property p_tx_int_drop;
		wd && ie_reg == 3'h2 |=> !intr;
	endproperty
	a_tx_int_drop: assert property (p_tx_int_drop)
		else $error("tx int held");
	// prompt start bit; bound assumes a divisor of five or less
	sequence s_load;
		single && wd && tx_dma_req;
	endsequence
	sequence s_start;
		##[1:60] !serial_tx_line;
	endsequence
	property p_start;
		s_load |-> s_start;
	endproperty
	a_start: assert property (p_start)
		else $error("no start bit");
endmodule : ufd_core_monitor
bind ufd_core ufd_core_monitor ufd_core_monitor_inst (.clock(clock),
	.reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
	.serial_tx_line(serial_tx_line), .intr(intr),
	.rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req));

// *** verification/ufd_serial_sink.sv ***
`timescale 1ns/10ps
module ufd_serial_sink #(
	parameter int DIV = 2
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// line in, byte out
	input  wire logic       serial_tx_line,
	output logic            byte_valid,
	output logic      [7:0] byte_data
);
	logic       busy;
	int         m;
	logic [7:0] sh;
	// frame capture, second half of each bit, lsb first
	always_ff @(posedge clock) begin
		byte_valid <= 1'b0;
		if (reset) begin
			busy <= 1'b0;
		end else if (!busy) begin
			busy <= !serial_tx_line;
			m <= 2;
		end else begin
			m <= m + 1;
			if ((m - 1) % DIV == DIV / 2) begin
				if ((m - 1) / DIV >= 1 && (m - 1) / DIV <= 8) begin
					sh <= {serial_tx_line, sh[7:1]};
				end
				if ((m - 1) / DIV == 9) begin
					busy <= 1'b0;
					byte_valid <= serial_tx_line;
					byte_data <= sh;
				end
			end
		end
	end
endmodule : ufd_serial_sink

// *** verification/uart_fifo_dma_control_tb.sv ***
`timescale 1ns/10ps
module uart_fifo_dma_control_tb;
	localparam int DIV = 2;
	logic       clock = 1'b0;
	logic       reset = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_write = 1'b0;
	logic       reg_read = 1'b0;
	logic       rx_char_valid = 1'b0;
	logic [7:0] rx_char_data = 8'h00;
	logic [7:0] reg_rdata;
	logic       serial_tx_line;
	logic       intr;
	logic       rx_dma_req;
	logic       tx_dma_req;
	logic       ser_valid;
	logic [7:0] ser_data;
	logic       rd_pend = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] msk_q[$];
	logic [7:0] rxq[$];
	logic [7:0] ser_q[$];
	logic [7:0] d;
	int         err_count = 0;
	int         samples_checked = 0;
	int         lv[4] = '{1, 4, 8, 14};
	int         i;
	ufd_core ufd_core_inst (.clock(clock), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata),
		.rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
		.serial_tx_line(serial_tx_line), .intr(intr),
		.rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req));
	ufd_serial_sink #(.DIV(DIV)) ufd_serial_sink_inst (.clock(clock),
		.reset(reset), .serial_tx_line(serial_tx_line),
		.byte_valid(ser_valid), .byte_data(ser_data));
	always #5 clock = ~clock;
	// ----------------------------------------------------------------
	// bus tasks and compares; each op starts just after an edge
	// ----------------------------------------------------------------
	task wr(input logic [2:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		reg_read <= 1'b0;
		if (a == ufd_pkg::OFS_DATA) ser_q.push_back(v);
		@(posedge clock);
	endtask : wr
	task rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] mk);
		exp_q.push_back(e);
		msk_q.push_back(mk);
		reg_addr <= a;
		reg_read <= 1'b1;
		reg_write <= 1'b0;
		@(posedge clock);
	endtask : rd
	task idle(input int n);
		reg_write <= 1'b0;
		reg_read <= 1'b0;
		repeat (n) @(posedge clock);
	endtask : idle
	// keep low models a character that overruns
	task rxc(input bit keep);
		d = 8'($urandom);
		if (keep) rxq.push_back(d);
		reg_write <= 1'b0;
		reg_read <= 1'b0;
		rx_char_valid <= 1'b1;
		rx_char_data <= d;
		@(posedge clock);
		rx_char_valid <= 1'b0;
		@(posedge clock);
	endtask : rxc
	task drain;
		while (rxq.size() > 0) rd(ufd_pkg::OFS_DATA, rxq.pop_front(), 8'hFF);
		idle(2);
	endtask : drain
	task check_bit(input string nm, input logic e, input logic s);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %b seen %b", nm, e, s);
		end
	endtask : check_bit
	task check_byte(string nm, logic [7:0] e, logic [7:0] s, logic [7:0] mk);
		samples_checked++;
		if ((s & mk) !== (e & mk)) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : check_byte
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test
	always @(posedge clock) begin
		if (rd_pend) check_byte("read", exp_q.pop_front(), reg_rdata,
			msk_q.pop_front());
		rd_pend <= reg_read && !reset;
		// a frame with nothing written is a fault of its own
		if (ser_valid) check_bit("serial due", 1'b1, ser_q.size() > 0);
		if (ser_valid) check_byte("serial", ser_q.pop_front(), ser_data,
			8'hFF);
	end
	initial begin
		#100000;
		err_count++;
		finish_test();
	end
	initial begin
		void'($urandom(25));
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		idle(1);
		rd(ufd_pkg::OFS_INT_FIFO, ufd_pkg::IID_NONE, 8'hFF);
		wr(ufd_pkg::OFS_DIV_LO, 8'(DIV));
		wr(ufd_pkg::OFS_DIV_HI, 8'h00);
		wr(ufd_pkg::OFS_INT_EN, 8'h01);
		rxc(1'b1);
		check_bit("level intr", 1'b1, intr);
		drain();
		$display("test unbuffered done");
		for (int t = 0; t < 4; t++) begin
			wr(ufd_pkg::OFS_INT_FIFO, {t[1:0], 6'h03});
			repeat (lv[t] - 1) rxc(1'b1);
			check_bit("below trigger", 1'b0, intr);
			rxc(1'b1);
			check_bit("at trigger", 1'b1, intr);
			if (t == 3) begin
				repeat (2) rxc(1'b1);
				rxc(1'b0);
				rd(ufd_pkg::OFS_LINE, 8'h02, 8'h02);
			end
			check_bit("rx single", 1'b1, rx_dma_req);
			drain();
			check_bit("rx empty", 1'b0, rx_dma_req);
		end
		$display("test trigger done");
		wr(ufd_pkg::OFS_INT_FIFO, 8'h83);
		rxc(1'b1);
		idle(70);
		check_bit("before timeout", 1'b0, intr);
		idle(30);
		check_bit("timeout", 1'b1, intr);
		rd(ufd_pkg::OFS_INT_FIFO, ufd_pkg::IID_TIMEOUT | ufd_pkg::IID_FIFO_ON,
			8'hFF);
		rxc(1'b1);
		check_bit("timeout clear", 1'b0, intr);
		drain();
		wr(ufd_pkg::OFS_INT_FIFO, 8'h4B);
		repeat (3) rxc(1'b1);
		check_bit("multi below", 1'b0, rx_dma_req);
		rxc(1'b1);
		check_bit("multi trigger", 1'b1, rx_dma_req);
		rd(ufd_pkg::OFS_DATA, rxq.pop_front(), 8'hFF);
		idle(2);
		check_bit("multi held", 1'b1, rx_dma_req);
		drain();
		check_bit("multi empty", 1'b0, rx_dma_req);
		$display("test rx timeout and multi done");
		wr(ufd_pkg::OFS_INT_EN, 8'h02);
		check_bit("tx free", 1'b1, tx_dma_req);
		for (i = 0; i < 18; i++) wr(ufd_pkg::OFS_DATA, 8'($urandom));
		void'(ser_q.pop_back());
		idle(1);
		check_bit("tx full", 1'b0, tx_dma_req);
		for (i = 0; i < 3000 && ser_q.size() > 0; i++) @(posedge clock);
		check_bit("tx drained", 1'b1, ser_q.size() == 0);
		check_bit("tx empty intr", 1'b1, intr);
		wr(ufd_pkg::OFS_INT_FIFO, 8'h01);
		wr(ufd_pkg::OFS_DATA, 8'($urandom));
		idle(1);
		check_bit("tx intr drop", 1'b0, intr);
		idle(5);
		check_bit("tx single", 1'b1, tx_dma_req);
		check_bit("tx hold-off", 1'b0, intr);
		idle(30);
		check_bit("tx hold-off end", 1'b1, intr);
		idle(20);
		check_bit("tx last sent", 1'b1, ser_q.size() == 0);
		$display("test transmit done");
		finish_test();
	end
endmodule : uart_fifo_dma_control_tb
